// ---- include/xps_pkg.sv ----
// package: offsets, field positions, reset values and address windows of the peripheral select
package xps_pkg;
  localparam int ADDR_W = 8;
  localparam int DATA_W = 16;
  localparam int BUS_ADDR_W = 24;
  // register offsets
  localparam logic [7:0] OFS_PERSEL = 8'h12;
  localparam logic [7:0] OFS_SYSCFG = 8'h00;
  localparam logic [7:0] OFS_STATUS = 8'h04;
  localparam logic [7:0] OFS_TIMING0 = 8'h08;
  localparam logic [7:0] OFS_TIMING1 = 8'h09;
  localparam logic [7:0] OFS_WINSEL0 = 8'h0a;
  localparam logic [7:0] OFS_WINSEL1 = 8'h0b;
  // field positions of the selection register
  localparam int BIT_CAN1 = 0;
  localparam int BIT_CAN2 = 1;
  localparam int BIT_RAM1 = 2;
  localparam int BIT_RAM2 = 3;
  localparam int BIT_CLK = 4;
  localparam int SEL_W = 5;
  localparam logic [4:0] SEL_RESET = 5'h05;
  localparam logic [4:0] SEL_ALL = 5'h1f;
  // field positions of the system configuration register
  localparam int BIT_GLOBAL_EN = 2;
  localparam int BIT_OSC_STOP = 0;
  // address windows, inclusive
  localparam logic [23:0] CAN_LO = 24'h00ee00;
  localparam logic [23:0] CAN_HI = 24'h00efff;
  localparam logic [23:0] RAM1_LO = 24'h00e000;
  localparam logic [23:0] RAM1_HI = 24'h00e7ff;
  localparam logic [23:0] RAM2_LO = 24'h00c000;
  localparam logic [23:0] RAM2_HI = 24'h00dfff;
  localparam logic [23:0] CLK_LO = 24'h00ec00;
  localparam logic [23:0] CLK_HI = 24'h00ecff;
  // external window select: upper address bits compared against a stored base
  localparam int WIN_SEL_LSB = 12;
  localparam int NUM_WIN = 2;
endpackage

// ---- include/xps_route_if.sv ----
// interface: effective selection handed to the address router and its answers
`timescale 1ns/100ps
interface xps_route_if;
  logic [4:0] sel_eff;
  logic [23:0] addr;
  logic [15:0] timing [2];
  logic [11:0] win_base [2];
  logic go_external;
  logic [15:0] timing_sel;
  logic timing_hit;
  modport ctrl (output sel_eff, output addr, output timing, output win_base,
                input go_external, input timing_sel, input timing_hit);
  modport route (input sel_eff, input addr, input timing, input win_base,
                 output go_external, output timing_sel, output timing_hit);
endinterface

// ---- rtl/xps_router.sv ----
// address router: decides external redirection and picks the bus timing
`timescale 1ns/100ps
module xps_router (
  // clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // selection and address
  xps_route_if.route rt
);
  logic can_any;
  logic in_can;
  logic in_ram1;
  logic in_ram2;
  logic in_clk;
  logic [1:0] hit;

  always_comb begin
    can_any = rt.sel_eff[xps_pkg::BIT_CAN1] | rt.sel_eff[xps_pkg::BIT_CAN2];
    in_can = rt.addr >= xps_pkg::CAN_LO && rt.addr <= xps_pkg::CAN_HI;
    in_ram1 = rt.addr >= xps_pkg::RAM1_LO && rt.addr <= xps_pkg::RAM1_HI;
    in_ram2 = rt.addr >= xps_pkg::RAM2_LO && rt.addr <= xps_pkg::RAM2_HI;
    in_clk = rt.addr >= xps_pkg::CLK_LO && rt.addr <= xps_pkg::CLK_HI;
    rt.go_external = (in_can && !can_any)
      || (in_ram1 && !rt.sel_eff[xps_pkg::BIT_RAM1])
      || (in_ram2 && !rt.sel_eff[xps_pkg::BIT_RAM2])
      || (in_clk && !rt.sel_eff[xps_pkg::BIT_CLK] && !can_any);
  end

  // lowest matching window wins; no match leaves timing zero
  genvar g;
  generate
    for (g = 0; g < xps_pkg::NUM_WIN; g++) begin : g_win
      assign hit[g] = rt.addr[23:xps_pkg::WIN_SEL_LSB] == rt.win_base[g];
    end
  endgenerate

  always_comb begin
    rt.timing_hit = |hit;
    if (hit[0]) begin
      rt.timing_sel = rt.timing[0];
    end else if (hit[1]) begin
      rt.timing_sel = rt.timing[1];
    end else begin
      rt.timing_sel = '0;
    end
  end

  property p_ram2_ext;
    @(posedge clk) disable iff (!rst_n)
      (in_ram2 && !rt.sel_eff[xps_pkg::BIT_RAM2]) |-> rt.go_external;
  endproperty
  a_ram2_ext: assert property (p_ram2_ext) else $error("large ram window not external");

  property p_can_int;
    @(posedge clk) disable iff (!rst_n)
      (in_can && can_any) |-> !rt.go_external;
  endproperty
  a_can_int: assert property (p_can_int) else $error("can window left chip while enabled");
endmodule

// ---- rtl/xps_top.sv ----
// peripheral select register bank with address routing and pin release
//
// Operation
// - both CAN off sends CAN window external
// - external access uses matching window timing
// - disabled CAN frees its two port lines
// - reset enables CAN1 and small RAM
// - global enable locks the selection register
// - emulation forces all selection bits on
// - clock calendar enable allows its access
// - calendar off stops oscillator in powerdown
// - calendar on, stop bit chooses oscillator
// - small RAM off sends its window external
// - large RAM off sends its window external
// - calendar off with both CAN off external
//
// The address-and-strobe port and the placing of the registers are this design's own decisions.
`timescale 1ns/100ps
module xps_top (
  // clock and reset
  input wire logic core_clk,
  input wire logic nrst,
  // register port
  input wire logic [7:0] reg_addr,
  input wire logic [15:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [15:0] reg_rdata,
  // mode and power pins
  input wire logic emulation_operation,
  input wire logic powerdown_req,
  input wire logic oscillator_powerdown_stop,
  // access address from the core
  input wire logic [23:0] bus_addr,
  // routing results
  output logic route_external,
  output logic [15:0] external_bus_timing,
  output logic calendar_access_ok,
  output logic oscillator_run,
  output logic first_can_pins_free,
  output logic second_can_pins_free
);
  logic rst_s1;
  logic rst_n;
  logic emu_s1;
  logic emu_s2;
  logic pd_s1;
  logic pd_s2;
  logic ostop_s1;
  logic ostop_s2;
  logic [4:0] bus_peripheral_select_reg;
  logic global_bus_peripheral_enable;
  logic [15:0] timing_reg [2];
  logic [11:0] base_reg [2];
  logic [4:0] sel_eff;
  logic [15:0] rdata_next;
  xps_route_if rt ();

  ////////////////////////////////////////////////////////////////////////////
  // reset release and input synchronisers
  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      rst_s1 <= 1'b0;
      rst_n <= 1'b0;
    end else begin
      rst_s1 <= 1'b1;
      rst_n <= rst_s1;
    end
  end

  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      emu_s1 <= 1'b0;
      emu_s2 <= 1'b0;
      pd_s1 <= 1'b0;
      pd_s2 <= 1'b0;
      ostop_s1 <= 1'b0;
      ostop_s2 <= 1'b0;
    end else begin
      emu_s1 <= emulation_operation;
      emu_s2 <= emu_s1;
      pd_s1 <= powerdown_req;
      pd_s2 <= pd_s1;
      ostop_s1 <= oscillator_powerdown_stop;
      ostop_s2 <= ostop_s1;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // registers
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      bus_peripheral_select_reg <= xps_pkg::SEL_RESET;
    end else if (reg_wr && reg_addr == xps_pkg::OFS_PERSEL
                 && !global_bus_peripheral_enable) begin
      bus_peripheral_select_reg <= reg_wdata[4:0];
    end
  end

  // the global enable is write-once: only reset clears it
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      global_bus_peripheral_enable <= 1'b0;
    end else if (reg_wr && reg_addr == xps_pkg::OFS_SYSCFG
                 && reg_wdata[xps_pkg::BIT_GLOBAL_EN]) begin
      global_bus_peripheral_enable <= 1'b1;
    end
  end

  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      timing_reg[0] <= '0;
      timing_reg[1] <= '0;
      base_reg[0] <= '0;
      base_reg[1] <= '0;
    end else if (reg_wr) begin
      if (reg_addr == xps_pkg::OFS_TIMING0) begin
        timing_reg[0] <= reg_wdata;
      end
      if (reg_addr == xps_pkg::OFS_TIMING1) begin
        timing_reg[1] <= reg_wdata;
      end
      if (reg_addr == xps_pkg::OFS_WINSEL0) begin
        base_reg[0] <= reg_wdata[11:0];
      end
      if (reg_addr == xps_pkg::OFS_WINSEL1) begin
        base_reg[1] <= reg_wdata[11:0];
      end
    end
  end

  always_comb begin
    sel_eff = emu_s2 ? xps_pkg::SEL_ALL : bus_peripheral_select_reg;
  end

  ////////////////////////////////////////////////////////////////////////////
  // read port
  always_comb begin
    rdata_next = '0;
    unique case (reg_addr)
      xps_pkg::OFS_PERSEL: rdata_next = {11'h000, sel_eff};
      xps_pkg::OFS_SYSCFG: rdata_next = {13'h0000, global_bus_peripheral_enable, 2'h0};
      xps_pkg::OFS_STATUS: rdata_next = {14'h0000, route_external, oscillator_run};
      xps_pkg::OFS_TIMING0: rdata_next = timing_reg[0];
      xps_pkg::OFS_TIMING1: rdata_next = timing_reg[1];
      xps_pkg::OFS_WINSEL0: rdata_next = {4'h0, base_reg[0]};
      xps_pkg::OFS_WINSEL1: rdata_next = {4'h0, base_reg[1]};
      default: rdata_next = '0;
    endcase
  end

  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      reg_rdata <= '0;
    end else if (reg_rd) begin
      reg_rdata <= rdata_next;
    end else begin
      reg_rdata <= '0;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // routing
  assign rt.sel_eff = sel_eff;
  assign rt.addr = bus_addr;
  assign rt.timing = timing_reg;
  assign rt.win_base = base_reg;

  xps_router u_router (
    .clk(core_clk),
    .rst_n(rst_n),
    .rt(rt.route)
  );

  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      route_external <= 1'b0;
      external_bus_timing <= '0;
    end else begin
      route_external <= rt.go_external;
      external_bus_timing <= rt.go_external ? rt.timing_sel : '0;
    end
  end

  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      calendar_access_ok <= 1'b0;
      oscillator_run <= 1'b1;
      first_can_pins_free <= 1'b0;
      second_can_pins_free <= 1'b1;
    end else begin
      calendar_access_ok <= sel_eff[xps_pkg::BIT_CLK];
      if (!pd_s2) begin
        oscillator_run <= 1'b1;
      end else if (!sel_eff[xps_pkg::BIT_CLK]) begin
        oscillator_run <= 1'b0;
      end else begin
        oscillator_run <= !ostop_s2;
      end
      first_can_pins_free <= !sel_eff[xps_pkg::BIT_CAN1];
      second_can_pins_free <= !sel_eff[xps_pkg::BIT_CAN2];
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // checks
  property p_lock;
    @(posedge core_clk) disable iff (!rst_n)
      global_bus_peripheral_enable |=> $stable(bus_peripheral_select_reg);
  endproperty
  a_lock: assert property (p_lock) else $error("selection changed after lock");

  property p_locked_write;
    @(posedge core_clk) disable iff (!rst_n)
      (global_bus_peripheral_enable && reg_wr && reg_addr == xps_pkg::OFS_PERSEL)
      |=> bus_peripheral_select_reg == $past(bus_peripheral_select_reg);
  endproperty
  a_locked_write: assert property (p_locked_write) else $error("locked write took effect");

  property p_emu;
    @(posedge core_clk) disable iff (!rst_n)
      emu_s2 |=> first_can_pins_free == 1'b0 && second_can_pins_free == 1'b0
        && calendar_access_ok;
  endproperty
  a_emu: assert property (p_emu) else $error("emulation did not force all on");

  property p_osc_off;
    @(posedge core_clk) disable iff (!rst_n)
      (pd_s2 && !sel_eff[xps_pkg::BIT_CLK]) |=> !oscillator_run;
  endproperty
  a_osc_off: assert property (p_osc_off) else $error("oscillator kept running");

  property p_osc_sel;
    @(posedge core_clk) disable iff (!rst_n)
      (pd_s2 && sel_eff[xps_pkg::BIT_CLK]) |=> oscillator_run == !$past(ostop_s2);
  endproperty
  a_osc_sel: assert property (p_osc_sel) else $error("stop bit ignored");

  property p_pins;
    @(posedge core_clk) disable iff (!rst_n)
      1'b1 |=> second_can_pins_free == !$past(sel_eff[xps_pkg::BIT_CAN2]);
  endproperty
  a_pins: assert property (p_pins) else $error("second can pins wrong");

  property p_cal;
    @(posedge core_clk) disable iff (!rst_n)
      1'b1 |=> calendar_access_ok == $past(sel_eff[xps_pkg::BIT_CLK]);
  endproperty
  a_cal: assert property (p_cal) else $error("calendar access flag wrong");

  property p_reset_val;
    @(posedge core_clk) $rose(rst_n) |-> bus_peripheral_select_reg == xps_pkg::SEL_RESET;
  endproperty
  a_reset_val: assert property (p_reset_val) else $error("bad reset selection");

  property p_timing;
    @(posedge core_clk) disable iff (!rst_n)
      (rt.go_external && rt.timing_hit) |=> external_bus_timing == $past(rt.timing_sel);
  endproperty
  a_timing: assert property (p_timing) else $error("external timing not taken");
endmodule

// ---- verif/xps_tb.sv ----
// self-checking testbench for the peripheral select register bank
`timescale 1ns/100ps
module testbench;
  logic core_clk = 1'b0;
  logic nrst = 1'b0;
  logic [7:0] reg_addr = 8'h00;
  logic [15:0] reg_wdata = 16'h0000;
  logic reg_wr = 1'b0;
  logic reg_rd = 1'b0;
  logic [15:0] reg_rdata;
  logic emulation_operation = 1'b0;
  logic powerdown_req = 1'b0;
  logic oscillator_powerdown_stop = 1'b0;
  logic [23:0] bus_addr = 24'h000000;
  logic route_external;
  logic [15:0] external_bus_timing;
  logic calendar_access_ok;
  logic oscillator_run;
  logic first_can_pins_free;
  logic second_can_pins_free;
  logic [15:0] rd_data;
  int n_fail = 0;
  int tests_run = 0;
  int cycles = 0;

  always #5 core_clk = ~core_clk;

  xps_top dut (
    .core_clk(core_clk), .nrst(nrst), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
    .emulation_operation(emulation_operation), .powerdown_req(powerdown_req),
    .oscillator_powerdown_stop(oscillator_powerdown_stop), .bus_addr(bus_addr),
    .route_external(route_external), .external_bus_timing(external_bus_timing),
    .calendar_access_ok(calendar_access_ok), .oscillator_run(oscillator_run),
    .first_can_pins_free(first_can_pins_free), .second_can_pins_free(second_can_pins_free)
  );

  ////////////////////////////////////////////////////////////////////////////
  task automatic report_and_stop();
    $display("comparisons %0d mismatches %0d", tests_run, n_fail);
    if (n_fail == 0 && tests_run > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask

  // hang guard, far above the fewer than two hundred cycles the tests need
  always @(posedge core_clk) begin
    cycles++;
    if (cycles == 20000) begin
      n_fail++;
      report_and_stop();
    end
  end

  task automatic chk(input string what, input logic [15:0] exp, input logic [15:0] got);
    tests_run++;
    if (got !== exp) begin
      n_fail++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
    end
  endtask

  task automatic bit_chk(input string what, input logic exp, input logic got);
    chk(what, {15'h0000, exp}, {15'h0000, got});
  endtask

  ////////////////////////////////////////////////////////////////////////////
  task automatic reg_write(input logic [7:0] a, input logic [15:0] d);
    @(posedge core_clk);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge core_clk);
    reg_wr <= 1'b0;
  endtask

  // read data stand only in the cycle after the strobe
  task automatic reg_read(input logic [7:0] a);
    @(posedge core_clk);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge core_clk);
    reg_rd <= 1'b0;
    #1;
    rd_data = reg_rdata;
  endtask

  task automatic settle(input int n);
    repeat (n) @(posedge core_clk);
    #1;
  endtask

  task automatic route(input logic [23:0] a, input logic ext);
    @(posedge core_clk);
    bus_addr <= a;
    settle(3);
    bit_chk("route_external", ext, route_external);
  endtask

  ////////////////////////////////////////////////////////////////////////////
  task automatic t_reset();
    reg_read(xps_pkg::OFS_PERSEL);
    chk("selection after reset", 16'h0005, rd_data);
    bit_chk("first pins free", 1'b0, first_can_pins_free);
    bit_chk("second pins free", 1'b1, second_can_pins_free);
    bit_chk("calendar access", 1'b0, calendar_access_ok);
    reg_read(8'h7f);
    chk("unmapped read", 16'h0000, rd_data);
    $display("test reset done");
  endtask

  task automatic t_route();
    reg_write(xps_pkg::OFS_PERSEL, 16'h0000);
    route(24'h00ee00, 1'b1);
    route(24'h00efff, 1'b1);
    route(24'h00ec10, 1'b1);
    route(24'h00e000, 1'b1);
    route(24'h00e7ff, 1'b1);
    route(24'h00c000, 1'b1);
    route(24'h00dfff, 1'b1);
    bit_chk("first pins free", 1'b1, first_can_pins_free);
    bit_chk("second pins free", 1'b1, second_can_pins_free);
    reg_write(xps_pkg::OFS_PERSEL, 16'h0002);
    route(24'h00ee10, 1'b0);
    route(24'h00ec10, 1'b0);
    bit_chk("first pins free", 1'b1, first_can_pins_free);
    bit_chk("second pins free", 1'b0, second_can_pins_free);
    reg_write(xps_pkg::OFS_PERSEL, 16'h001f);
    route(24'h00e010, 1'b0);
    route(24'h00c010, 1'b0);
    bit_chk("calendar access", 1'b1, calendar_access_ok);
    $display("test route done");
  endtask

  task automatic t_timing();
    reg_write(xps_pkg::OFS_TIMING0, 16'h1234);
    reg_write(xps_pkg::OFS_TIMING1, 16'h5678);
    reg_write(xps_pkg::OFS_WINSEL0, 16'h000e);
    reg_write(xps_pkg::OFS_WINSEL1, 16'h000c);
    reg_write(xps_pkg::OFS_PERSEL, 16'h0000);
    route(24'h00ee10, 1'b1);
    chk("timing window 0", 16'h1234, external_bus_timing);
    route(24'h00c010, 1'b1);
    chk("timing window 1", 16'h5678, external_bus_timing);
    reg_write(xps_pkg::OFS_PERSEL, 16'h001f);
    route(24'h00ee10, 1'b0);
    chk("timing internal", 16'h0000, external_bus_timing);
    $display("test timing done");
  endtask

  task automatic t_osc();
    reg_write(xps_pkg::OFS_PERSEL, 16'h000f);
    @(posedge core_clk);
    powerdown_req <= 1'b1;
    oscillator_powerdown_stop <= 1'b0;
    settle(6);
    bit_chk("oscillator calendar off", 1'b0, oscillator_run);
    reg_write(xps_pkg::OFS_PERSEL, 16'h001f);
    settle(4);
    bit_chk("oscillator keep", 1'b1, oscillator_run);
    reg_read(xps_pkg::OFS_STATUS);
    chk("status oscillator running", 16'h0001, rd_data);
    @(posedge core_clk);
    oscillator_powerdown_stop <= 1'b1;
    settle(6);
    bit_chk("oscillator stop", 1'b0, oscillator_run);
    @(posedge core_clk);
    powerdown_req <= 1'b0;
    settle(6);
    bit_chk("oscillator awake", 1'b1, oscillator_run);
    $display("test oscillator done");
  endtask

  task automatic t_emul();
    reg_write(xps_pkg::OFS_PERSEL, 16'h0000);
    @(posedge core_clk);
    emulation_operation <= 1'b1;
    settle(6);
    reg_read(xps_pkg::OFS_PERSEL);
    chk("selection emulation", 16'h001f, rd_data);
    route(24'h00ee10, 1'b0);
    bit_chk("first pins emulation", 1'b0, first_can_pins_free);
    @(posedge core_clk);
    emulation_operation <= 1'b0;
    settle(6);
    reg_read(xps_pkg::OFS_PERSEL);
    chk("selection after emulation", 16'h0000, rd_data);
    $display("test emulation done");
  endtask

  task automatic t_lock();
    reg_write(xps_pkg::OFS_PERSEL, 16'h000a);
    reg_write(xps_pkg::OFS_SYSCFG, 16'h0004);
    reg_read(xps_pkg::OFS_SYSCFG);
    chk("global enable readback", 16'h0004, rd_data);
    reg_write(xps_pkg::OFS_PERSEL, 16'h0015);
    reg_read(xps_pkg::OFS_PERSEL);
    chk("selection locked", 16'h000a, rd_data);
    route(24'h00c010, 1'b0);
    bit_chk("first pins locked", 1'b1, first_can_pins_free);
    bit_chk("second pins locked", 1'b0, second_can_pins_free);
    $display("test lock done");
  endtask

  // reset in mid-run: selection back to its reset value and the lock released
  task automatic t_rerst();
    @(posedge core_clk);
    nrst <= 1'b0;
    settle(3);
    @(posedge core_clk);
    nrst <= 1'b1;
    settle(5);
    reg_read(xps_pkg::OFS_PERSEL);
    chk("selection after second reset", 16'h0005, rd_data);
    reg_write(xps_pkg::OFS_PERSEL, 16'h0010);
    reg_read(xps_pkg::OFS_PERSEL);
    chk("selection unlocked by reset", 16'h0010, rd_data);
    route(24'h00ec10, 1'b0);
    route(24'h00ee10, 1'b1);
    chk("timing no window", 16'h0000, external_bus_timing);
    $display("test second reset done");
  endtask

  ////////////////////////////////////////////////////////////////////////////
  initial begin
    repeat (12) @(posedge core_clk);
    nrst <= 1'b1;
    settle(5);
    t_reset();
    t_route();
    t_timing();
    t_osc();
    t_emul();
    t_lock();
    t_rerst();
    report_and_stop();
  end
endmodule
